/* dv/edm_check_assertions.sv */
`timescale 1ns/1ps
module edm_check_assertions #(parameter int unsigned OPEN_LIMIT_CYC = 50, CLOSE_CYC = 20) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire edm_pkg::edm_mode_t MON_MODE,
    input wire logic SAFE_REQ,
    input wire logic MONITOR_FB,
    input wire logic FAULT_CLEAR,
    input wire logic SAFETY_OUTPUT_PAIR_1,
    input wire logic SAFETY_OUTPUT_PAIR_2,
    input wire edm_pkg::edm_status_t STATUS
);
    import edm_pkg::*;
    int unsigned on_ff, cls_ff;
    wire p   = SAFETY_OUTPUT_PAIR_1;
    wire one = MON_MODE == MON_ONE_CH;
    wire f   = STATUS.fault;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // cycles on, and cycles the chain stays open after off
    always_ff @(posedge MCLK or negedge RESET_N)
        if (!RESET_N) begin
            on_ff  <= 0;
            cls_ff <= 0;
        end else begin
            on_ff  <= p ? on_ff + 1 : 0;
            cls_ff <= $fell(p) ? 1 : (cls_ff != 0 && !MONITOR_FB) ? cls_ff + 1 : 0;
        end
    property p_on; $rose(p) && MON_MODE != MON_NONE |-> $past(MONITOR_FB, 4); endproperty
    a_on: assert property (p_on) else $error("on with chain open");
    property p_open; p && on_ff == OPEN_LIMIT_CYC + 6 && one |-> !MONITOR_FB; endproperty
    a_open: assert property (p_open) else $error("chain never opened");
    property p_cls; cls_ff == CLOSE_CYC + 8 && one |-> f; endproperty
    a_cls: assert property (p_cls) else $error("late close unseen");
    property p_none; MON_MODE == MON_NONE && $past(MON_MODE) == MON_NONE |-> !$rose(f); endproperty
    a_none: assert property (p_none) else $error("fault unmonitored");
    property p_off; f |-> !p && !SAFETY_OUTPUT_PAIR_2; endproperty
    a_off: assert property (p_off) else $error("on in fault");
    property p_hold; !FAULT_CLEAR [*6] ##0 f |=> f; endproperty
    a_hold: assert property (p_hold) else $error("fault lost");
    property p_early; $fell(p) && $past(SAFE_REQ) |-> $past(on_ff) + 2 >= OPEN_LIMIT_CYC; endproperty
    a_early: assert property (p_early) else $error("early trip");
    property p_pair; p == SAFETY_OUTPUT_PAIR_2 && STATUS.pair_on == p; endproperty
    a_pair: assert property (p_pair) else $error("pair split");
    cover property ($rose(p) && one);
    cover property ($rose(f));
    cover property ($rose(p) && MON_MODE == MON_NONE);
endmodule

/* dv/edm_contacts.sv */
`timescale 1ns/1ps
module edm_contacts (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       coil,
    input  wire logic       hold,
    input  wire logic [7:0] dly,
    output logic            fb
);
    logic [7:0] cnt_ff;
    always_ff @(posedge clk or negedge rst_n) // nc chain, inverse of coils after dly
        if (!rst_n) {fb, cnt_ff} <= 9'h100;
        else if (hold || fb != coil) cnt_ff <= 8'h00;
        else if (cnt_ff == dly) fb <= ~coil;
        else cnt_ff <= cnt_ff + 8'h01;
endmodule

/* dv/test_edm_check.sv */
`timescale 1ns/1ps
module test_edm_check;
    import edm_pkg::*;
    logic clk = 0, rst_n = 0, safe = 0, rs = 0, clr = 0, hold = 0, fb, p1, p2;
    logic [7:0] dly = 8'h0a;
    edm_mode_t mode = MON_ONE_CH;
    edm_status_t st;
    wire [3:0] obs = {p1, p2, st.fault, st.restart_blocked};
    int errors = 0, total_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin errors++; summarize(); end
    edm_check #(.OPEN_LIMIT_CYC(50), .CLOSE_CYC(20)) edm_check_i (.MCLK(clk), .RESET_N(rst_n),
        .MON_MODE(mode), .SAFE_REQ(safe), .RESTART_REQ(rs), .MONITOR_FB(fb), .FAULT_CLEAR(clr),
        .SAFETY_OUTPUT_PAIR_1(p1), .SAFETY_OUTPUT_PAIR_2(p2), .STATUS(st));
    edm_contacts edm_contacts_i (.clk(clk), .rst_n(rst_n), .coil(p1), .hold(hold), .dly(dly), .fb(fb));
    task tk(input int n); repeat (n) @(posedge clk); #1; endtask
    task go; rs = 1; tk(8); rs = 0; tk(3); endtask
    task clear; clr = 1; tk(8); clr = 0; tk(6); endtask
    task check(input logic [3:0] seen, exp);
        total_checks++; if (seen !== exp) begin errors++; $display("unexpected %0t: %h", $time, seen); end
    endtask
    task t_fault;
        hold = 1; safe = 1; go(); tk(60); check(obs, 4'h2);
        safe = 0; hold = 0; tk(20); check(obs, 4'h2);
        clear(); safe = 1; go(); tk(20); hold = 1; safe = 0; tk(30); check(obs, 4'h2);
        clear(); safe = 1; go(); check(obs, 4'h1);
        hold = 0; tk(20); go(); check(obs, 4'hc);
        tk(60); check(obs, 4'hc);
        safe = 0; tk(30); check(obs, 4'h0);
        $display("fault test done");
    endtask
    task t_modes;
        mode = MON_NONE; hold = 1; safe = 1; go(); tk(60); check(obs, 4'hc);
        hold = 0; tk(20); hold = 1; safe = 0; tk(30); check(obs, 4'h0);
        mode = MON_ABSENT; safe = 1; go(); check(obs & 4'hc, 4'h0);
        hold = 0; tk(20); go(); check(obs, 4'hc);
        safe = 0; tk(30); $display("mode test done");
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tk(5); rst_n = 1; tk(2); t_fault(); t_modes(); summarize();
    end
endmodule
bind edm_check edm_check_assertions #(.OPEN_LIMIT_CYC(OPEN_LIMIT_CYC), .CLOSE_CYC(CLOSE_CYC))
    edm_check_assertions_i (.MCLK, .RESET_N, .MON_MODE, .SAFE_REQ, .MONITOR_FB, .FAULT_CLEAR,
    .SAFETY_OUTPUT_PAIR_1, .SAFETY_OUTPUT_PAIR_2, .STATUS);

/* rtl/edm_check.sv */
`timescale 1ns/1ps
module edm_check #(
    parameter int unsigned OPEN_LIMIT_CYC = edm_pkg::OPEN_LIMIT_MAX_CYC,
    parameter int unsigned CLOSE_CYC      = edm_pkg::CLOSE_LIMIT_CYC
) (
    input  wire logic              MCLK,
    input  wire logic              RESET_N,
    input  wire edm_pkg::edm_mode_t MON_MODE,
    input  wire logic              SAFE_REQ,
    input  wire logic              RESTART_REQ,
    input  wire logic              MONITOR_FB,
    input  wire logic              FAULT_CLEAR,
    output logic                   SAFETY_OUTPUT_PAIR_1,
    output logic                   SAFETY_OUTPUT_PAIR_2,
    output edm_pkg::edm_status_t   STATUS
);
    import edm_pkg::*;

    // ****************************************************************
    // input conditioning
    // ****************************************************************
    logic fb_closed;
    logic restart_s;
    logic clear_s;

    // chain level, high while every contact is closed
    edm_sync u_sync_fb (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .din   (MONITOR_FB),
        .dout  (fb_closed)
    );

    // restart switch, only its rising edge is used
    edm_sync u_sync_rst (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .din   (RESTART_REQ),
        .dout  (restart_s)
    );

    // fault clear, acted on as a level
    edm_sync u_sync_clr (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .din   (FAULT_CLEAR),
        .dout  (clear_s)
    );

    // ****************************************************************
    // state and timer
    // ****************************************************************
    edm_state_t         state_ff;
    edm_state_t         nxt_state;
    logic [TIMER_W-1:0] timer_ff;
    logic [TIMER_W-1:0] nxt_timer;
    logic               restart_d_ff;

    // ****************************************************************
    // window limits
    // ****************************************************************
    // a larger setting is clamped so the open window never grows past its ceiling
    localparam int unsigned OPEN_EFF =
        (OPEN_LIMIT_CYC > OPEN_LIMIT_MAX_CYC) ? OPEN_LIMIT_MAX_CYC : OPEN_LIMIT_CYC;
    localparam logic [TIMER_W-1:0] OPEN_LIM  = TIMER_W'(OPEN_EFF);
    localparam logic [TIMER_W-1:0] CLOSE_LIM = TIMER_W'(CLOSE_CYC);

    // ****************************************************************
    // mode decode
    // ****************************************************************
    wire checking     = (MON_MODE == MON_ONE_CH);
    wire timer_done   = checking ? 1'b0 : 1'b1;

    // ****************************************************************
    // restart qualification
    // ****************************************************************
    wire restart_edge = restart_s & ~restart_d_ff;
    // variant: open chain in series with restart blocks it
    wire restart_ok   = (MON_MODE == MON_ABSENT) ? (restart_edge & fb_closed)
                                                 : restart_edge;
    wire close_ok     = ~checking | fb_closed;

    // ****************************************************************
    // window checks
    // ****************************************************************
    wire open_late    = checking & fb_closed & (timer_ff >= OPEN_LIM);
    wire close_late   = checking & ~fb_closed & (timer_ff >= CLOSE_LIM);

    // ****************************************************************
    // state machine
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff + TIMER_W'(1);
        case (state_ff)
            // idle: request, restart edge and, except in MON_NONE, closed chain
            ST_OFF: begin
                nxt_timer = '0;
                if (SAFE_REQ && restart_ok && close_ok) begin
                    nxt_state = ST_ON_WAIT;
                end
            end

            // pair on, chain must open in time
            ST_ON_WAIT: begin
                if (!SAFE_REQ) begin
                    nxt_state = ST_OFF_WAIT;
                    nxt_timer = '0;
                end else if (timer_done || !fb_closed) begin
                    nxt_state = ST_ON;
                end else if (open_late) begin
                    nxt_state = ST_FAULT;
                end
            end

            // pair on, chain seen open (MON_ONE_CH) or not checked (other modes)
            ST_ON: begin
                if (!SAFE_REQ) begin
                    nxt_state = ST_OFF_WAIT;
                    nxt_timer = '0;
                end
            end

            // pair off, chain must reclose in time
            ST_OFF_WAIT: begin
                if (timer_done || fb_closed) begin
                    nxt_state = ST_OFF;
                end else if (close_late) begin
                    nxt_state = ST_FAULT;
                end
            end

            // latched until cleared
            ST_FAULT: begin
                nxt_timer = '0;
                if (clear_s) begin
                    nxt_state = ST_OFF;
                end
            end
            default: begin
                nxt_state = ST_FAULT;
                nxt_timer = '0;
            end
        endcase
    end

    // ****************************************************************
    // next values of the registered outputs
    // ****************************************************************
    wire pair_next    = (nxt_state == ST_ON_WAIT) || (nxt_state == ST_ON);
    wire fault_next   = (nxt_state == ST_FAULT);
    // turn-on wanted while the chain is seen open, in MON_ONE_CH mode only
    wire blocked_next = (nxt_state == ST_OFF) && SAFE_REQ && !close_ok;

    // ****************************************************************
    // state registers
    // ****************************************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timer_ff <= '0;
        end else begin
            timer_ff <= nxt_timer;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            restart_d_ff <= 1'b0;
        end else begin
            restart_d_ff <= restart_s;
        end
    end

    // ****************************************************************
    // output registers
    // ****************************************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SAFETY_OUTPUT_PAIR_1 <= OUT_RST;
        end else begin
            SAFETY_OUTPUT_PAIR_1 <= pair_next;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SAFETY_OUTPUT_PAIR_2 <= OUT_RST;
        end else begin
            SAFETY_OUTPUT_PAIR_2 <= pair_next;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            STATUS <= '0;
        end else begin
            STATUS.pair_on         <= pair_next;
            STATUS.fault           <= fault_next;
            STATUS.restart_blocked <= blocked_next;
        end
    end
endmodule

/* rtl/edm_pkg.sv */
package edm_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_PS       = 8000;
    localparam int unsigned OPEN_LIMIT_MAX_MS   = 350;
    localparam int unsigned CLOSE_LIMIT_MS      = 100;
    localparam longint unsigned PS_PER_MS       = 64'd1000000000;
    localparam int unsigned OPEN_LIMIT_MAX_CYC  =
        int'((OPEN_LIMIT_MAX_MS * PS_PER_MS) / CLK_PERIOD_PS);
    localparam int unsigned CLOSE_LIMIT_CYC     =
        int'((CLOSE_LIMIT_MS * PS_PER_MS) / CLK_PERIOD_PS);
    localparam int unsigned TIMER_W             = 26;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [2:0] SYNC_RST  = 3'h0;
    localparam logic       OUT_RST   = 1'b0;

    typedef enum logic [1:0] {
        MON_NONE    = 2'b00,
        MON_ONE_CH  = 2'b01,
        MON_ABSENT  = 2'b10
    } edm_mode_t;

    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_ON_WAIT  = 3'b001,
        ST_ON       = 3'b010,
        ST_OFF_WAIT = 3'b011,
        ST_FAULT    = 3'b100
    } edm_state_t;

    typedef struct packed {
        logic pair_on;
        logic fault;
        logic restart_blocked;
    } edm_status_t;

endpackage

/* rtl/edm_sync.sv */
`timescale 1ns/1ps
module edm_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    import edm_pkg::*;

    logic [2:0] sh_ff;

    // ****************************************************************
    // three stages; level accepted when the last two agree
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff <= SYNC_RST;
            dout  <= 1'b0;
        end else begin
            sh_ff <= {sh_ff[1:0], din};
            if (sh_ff[1] == sh_ff[2]) begin
                dout <= sh_ff[2];
            end
        end
    end
endmodule
